// ==== src/serial_modem_control_lines.sv ====
// modem-control lines of the serial data port: dcd, dsr, cts, dtr handling
`timescale 1ns/100ps
module serial_modem_control_lines (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire modem_lines_pkg::line_cfg_t cfg_i,
  input wire modem_lines_pkg::radio_status_t radio_i,
  input wire logic dtr_asserted_i,
  input wire logic rts_i,
  input wire logic tx_active_i,
  input wire logic rx_space_i,
  input wire logic enter_data_i,
  input wire logic enter_command_i,
  output modem_lines_pkg::line_pins_t pins_o,
  output logic tx_allowed_o,
  output logic data_mode_o,
  output logic drop_link_o,
  output logic data_refused_o,
  output logic cfg_error_o
);
  import modem_lines_pkg::*;

  // rs485 variants are every interface code other than rs232
  function automatic logic is_rs485(input logic [1:0] iface);
    is_rs485 = (iface != IFACE_RS232);
  endfunction : is_rs485

  // carrier-detect decision for a policy and the radio status
  function automatic logic dcd_wanted(input logic [2:0] policy,
                                      input radio_status_t st);
    logic radio_ok;
    radio_ok = 1'b0;
    if (st.hopping_operation) begin
      radio_ok = st.synced;
    end else if (st.narrowband_operation) begin
      radio_ok = (policy == DCD_SYNC_BUSY) ? st.channel_busy : !st.channel_busy;
    end
    if ((policy == DCD_SYNC_IDLE) || (policy == DCD_SYNC_BUSY)) begin
      dcd_wanted = radio_ok;
    end else begin
      dcd_wanted = 1'b1;
    end
  endfunction : dcd_wanted

  // reset release through two flip-flops
  logic rst_n;
  sync2 u_rst_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // dtr is brought into the clock domain and sampled once more
  logic dtr_sync;
  logic dtr_level;
  logic dtr_change;
  sync2 u_dtr_sync (
    .clock_i(clock_i),
    .nrst_i(rst_n),
    .d_i(dtr_asserted_i),
    .q_o(dtr_sync)
  );
  change_detect u_dtr_change (
    .clock_i(clock_i),
    .nrst_i(rst_n),
    .d_i(dtr_sync),
    .level_o(dtr_level),
    .change_o(dtr_change)
  );

  mode_t mode_ff;
  mode_t nxt_mode;
  logic forced_ff;
  logic nxt_forced;
  line_pins_t pins_ff;
  line_pins_t nxt_pins;
  logic tx_allowed_ff;
  logic nxt_tx_allowed;
  logic drop_link_ff;
  logic data_refused_ff;
  logic cfg_error_ff;
  logic nxt_cfg_error;
  logic data_mode_ff;

  // mode requests
  wire in_data = (mode_ff == MODE_DATA);
  wire dtr_drop_policy = (cfg_i.dtr_policy == DTR_DROP);
  // policy 0 (and undefined codes) never lets dtr act
  wire dtr_drop = in_data && dtr_drop_policy && dtr_change;
  // a forced drop blocks re-entry until dtr is seen asserted again
  wire data_blocked = forced_ff && !dtr_level;
  wire data_enter = !in_data && enter_data_i && !data_blocked;
  wire data_refuse = !in_data && enter_data_i && data_blocked;
  wire cmd_enter = in_data && (enter_command_i || dtr_drop);

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_COMMAND: begin
        if (data_enter) begin
          nxt_mode = MODE_DATA;
        end
      end
      MODE_DATA: begin
        if (cmd_enter) begin
          nxt_mode = MODE_COMMAND;
        end
      end
    endcase
  end

  // forced flag: set by a dtr drop, cleared by dtr asserted; set wins
  assign nxt_forced = dtr_drop || (forced_ff && !dtr_level);

  // dsr follows the mode being entered so it moves with data_mode_o
  wire nxt_in_data = (nxt_mode == MODE_DATA);
  wire dsr_by_mode = nxt_in_data ? DSR_ON_LEVEL : DSR_OFF_LEVEL;
  assign nxt_pins.dsr_level = (cfg_i.dsr_policy == DSR_BY_MODE) ?
                              dsr_by_mode : DSR_ON_LEVEL;

  assign nxt_pins.dcd_on = dcd_wanted(cfg_i.dcd_policy, radio_i);

  // flow control; no character path exists here, so only pins pace data
  wire flow_none = (cfg_i.flow_control == FLOW_NONE);
  wire flow_rs485 = (cfg_i.flow_control == FLOW_RS485);
  wire flow_hw = (cfg_i.flow_control == FLOW_RTS_CTS);
  wire cts_hw = rx_space_i;
  wire cts_rs485 = tx_active_i;
  assign nxt_pins.cts = flow_rs485 ? cts_rs485 : flow_hw ? cts_hw : 1'b1;
  // host rts alone gates our transmitter; in-band pacing is never honoured
  assign nxt_tx_allowed = flow_hw ? rts_i : 1'b1;

  // configuration consistency
  wire rs485_sel = is_rs485(cfg_i.line_interface_select);
  wire flow_bad_232 = !rs485_sel && !(flow_none || flow_hw);
  wire flow_bad_485 = rs485_sel && !flow_rs485;
  wire dcd_bad = !((cfg_i.dcd_policy == DCD_ALWAYS) ||
                   (cfg_i.dcd_policy == DCD_SYNC_IDLE) ||
                   (cfg_i.dcd_policy == DCD_SYNC_BUSY));
  wire dtr_bad = !((cfg_i.dtr_policy == DTR_IGNORE) || dtr_drop_policy);
  assign nxt_cfg_error = flow_bad_232 || flow_bad_485 || dcd_bad || dtr_bad;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_COMMAND;
      forced_ff <= RST_FORCED;
    end else begin
      mode_ff <= nxt_mode;
      forced_ff <= nxt_forced;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_ff <= '{dcd_on: RST_DCD_ON, dsr_level: RST_DSR_LEVEL, cts: RST_CTS};
      tx_allowed_ff <= RST_TX_ALLOWED;
      data_mode_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      tx_allowed_ff <= nxt_tx_allowed;
      // copy of the mode flop so the output leaves a register directly
      data_mode_ff <= nxt_in_data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      drop_link_ff <= RST_PULSE;
      data_refused_ff <= RST_PULSE;
      cfg_error_ff <= RST_CFG_ERROR;
    end else begin
      drop_link_ff <= dtr_drop;
      data_refused_ff <= data_refuse;
      cfg_error_ff <= nxt_cfg_error;
    end
  end

  assign pins_o = pins_ff;
  assign tx_allowed_o = tx_allowed_ff;
  assign data_mode_o = data_mode_ff;
  assign drop_link_o = drop_link_ff;
  assign data_refused_o = data_refused_ff;
  assign cfg_error_o = cfg_error_ff;

endmodule : serial_modem_control_lines

// ==== src/modem_lines_pkg.sv ====
// constants and carrier types for the serial modem-control line logic
package modem_lines_pkg;

  // carrier-detect policy codes
  localparam logic [2:0] DCD_ALWAYS = 3'h0;
  localparam logic [2:0] DCD_SYNC_IDLE = 3'h1;
  localparam logic [2:0] DCD_SYNC_BUSY = 3'h4;

  // terminal-ready policy codes
  localparam logic [1:0] DTR_IGNORE = 2'h0;
  localparam logic [1:0] DTR_DROP = 2'h2;

  // flow-control setting codes
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_RS485 = 2'h1;
  localparam logic [1:0] FLOW_RTS_CTS = 2'h3;

  // data-set-ready policy codes
  localparam logic DSR_ALWAYS = 1'h0;
  localparam logic DSR_BY_MODE = 1'h1;

  // line interface selection: 0 is rs232, 1 to 3 are rs485 variants
  localparam logic [1:0] IFACE_RS232 = 2'h0;

  // electrical level of the dsr pin
  localparam logic DSR_ON_LEVEL = 1'h0;
  localparam logic DSR_OFF_LEVEL = 1'h1;

  // values held during and right after reset
  localparam logic RST_DCD_ON = 1'h0;
  localparam logic RST_DSR_LEVEL = DSR_OFF_LEVEL;
  localparam logic RST_CTS = 1'h0;
  localparam logic RST_TX_ALLOWED = 1'h0;
  localparam logic RST_PULSE = 1'h0;
  localparam logic RST_CFG_ERROR = 1'h0;
  localparam logic RST_FORCED = 1'h0;
  localparam logic RST_SYNC = 1'h0;

  typedef enum logic {
    MODE_COMMAND,
    MODE_DATA
  } mode_t;

  typedef struct packed {
    logic [2:0] dcd_policy;
    logic [1:0] dtr_policy;
    logic [1:0] flow_control;
    logic dsr_policy;
    logic [1:0] line_interface_select;
  } line_cfg_t;

  typedef struct packed {
    logic hopping_operation;
    logic narrowband_operation;
    logic synced;
    logic channel_busy;
  } radio_status_t;

  typedef struct packed {
    logic dcd_on;
    logic dsr_level;
    logic cts;
  } line_pins_t;

endpackage : modem_lines_pkg

// ==== src/sync2.sv ====
// two flip-flop synchroniser for a single level
`timescale 1ns/100ps
module sync2 (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic q_o
);
  import modem_lines_pkg::*;

  logic meta_ff;
  logic q_ff;

  // the first stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= RST_SYNC;
      q_ff <= RST_SYNC;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule : sync2

// ==== src/change_detect.sv ====
// registered sample of a synchronised level and its change strobe
`timescale 1ns/100ps
module change_detect (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic level_o,
  output logic change_o
);
  import modem_lines_pkg::*;

  logic sample_ff;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_ff <= RST_SYNC;
    end else begin
      sample_ff <= d_i;
    end
  end

  // both operands are registered, so the strobe is glitch-free
  assign change_o = d_i ^ sample_ff;
  assign level_o = sample_ff;

endmodule : change_detect

// ==== testbench/host_model.sv ====
// host-side model driving the dtr and rts lines toward the device
`timescale 1ns/100ps
module host_model (
  input wire logic clock_i,
  output logic dtr_o,
  output logic rts_o
);
  initial begin
    dtr_o = 1'h0;
    rts_o = 1'h0;
  end
  // paces with rts only, never with in-band characters
  task automatic set_lines(input logic dtr, input logic rts);
    @(negedge clock_i);
    dtr_o = dtr;
    rts_o = rts;
  endtask : set_lines
endmodule : host_model

// ==== testbench/modem_lines_checker.sv ====
// assertions on the modem-control line ports
`timescale 1ns/100ps
module modem_lines_checker (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire modem_lines_pkg::line_cfg_t cfg_i,
  input wire modem_lines_pkg::radio_status_t radio_i,
  input wire logic dtr_asserted_i,
  input wire logic rts_i,
  input wire logic tx_active_i,
  input wire logic rx_space_i,
  input wire logic enter_data_i,
  input wire logic enter_command_i,
  input wire modem_lines_pkg::line_pins_t pins_o,
  input wire logic tx_allowed_o,
  input wire logic data_mode_o,
  input wire logic drop_link_o,
  input wire logic data_refused_o,
  input wire logic cfg_error_o
);
  import modem_lines_pkg::*;
  logic [1:0] up_ff;
  // outputs are trusted only once the internal reset copy has let go
  wire ok = up_ff == 2'h3;
  wire hop = radio_i.hopping_operation;
  wire idle_on = hop ? radio_i.synced : radio_i.narrowband_operation & ~radio_i.channel_busy;
  wire busy_on = hop ? radio_i.synced : radio_i.narrowband_operation & radio_i.channel_busy;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) up_ff <= 2'h0;
    else if (!ok) up_ff <= up_ff + 2'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_dcd_always: assert property (ok && cfg_i.dcd_policy == DCD_ALWAYS |=> pins_o.dcd_on)
    else $error("dcd off");
  a_dcd_idle: assert property (ok && cfg_i.dcd_policy == DCD_SYNC_IDLE |=> pins_o.dcd_on == $past(idle_on))
    else $error("dcd idle");
  a_dcd_busy: assert property (ok && cfg_i.dcd_policy == DCD_SYNC_BUSY |=> pins_o.dcd_on == $past(busy_on))
    else $error("dcd busy");
  a_dtr_ignored: assert property ((ok && cfg_i.dtr_policy == DTR_IGNORE) [*4] |-> !drop_link_o)
    else $error("dtr not ignored");
  a_dtr_drop: assert property (ok && cfg_i.dtr_policy == DTR_DROP && data_mode_o && !enter_command_i
    && $changed(dtr_asserted_i) |-> ##3 drop_link_o && !data_mode_o) else $error("no drop");
  a_dsr_on: assert property (ok && cfg_i.dsr_policy == DSR_ALWAYS |=> pins_o.dsr_level == DSR_ON_LEVEL)
    else $error("dsr off");
  a_dsr_mode: assert property (ok && cfg_i.dsr_policy == DSR_BY_MODE && $stable(cfg_i.dsr_policy)
    |-> pins_o.dsr_level == !data_mode_o) else $error("dsr mode");
  a_cts_rs485: assert property (ok && cfg_i.flow_control == FLOW_RS485 |=> pins_o.cts == $past(tx_active_i))
    else $error("cts rs485");
  a_flow_hand: assert property (ok && cfg_i.flow_control == FLOW_RTS_CTS |=>
    pins_o.cts == $past(rx_space_i) && tx_allowed_o == $past(rts_i)) else $error("handshake");
endmodule : modem_lines_checker
bind serial_modem_control_lines modem_lines_checker u_chk (.*);

// ==== testbench/serial_modem_control_lines_tb_top.sv ====
// self-checking bench for the modem-control line logic
`timescale 1ns/100ps
module serial_modem_control_lines_tb_top;
  import modem_lines_pkg::*;
  logic clock_i = 1'h0, nrst_i = 1'h0, tx_active_i = 1'h0, rx_space_i = 1'h0;
  logic enter_data_i = 1'h0, enter_command_i = 1'h0, dtr_asserted_i, rts_i;
  line_cfg_t cfg_i = '0;
  radio_status_t radio_i = '0;
  line_pins_t pins_o;
  logic tx_allowed_o, data_mode_o, drop_link_o, data_refused_o, cfg_error_o;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #4 clock_i = ~clock_i;
  host_model u_host (.clock_i(clock_i), .dtr_o(dtr_asserted_i), .rts_o(rts_i));
  serial_modem_control_lines u_dut (.*);
  task automatic chk(input string name, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask : tick
  task automatic dcd_case(input logic [2:0] pol, input logic [3:0] st, input logic exp);
    tick(1);
    cfg_i.dcd_policy = pol;
    radio_i = st;
    tick(1);
    chk("dcd_on", pins_o.dcd_on, exp);
  endtask : dcd_case
  // in is rts, tx_active, rx_space; ex is cts, tx_allowed, cfg_error
  task automatic flow_case(input logic [1:0] f, ifc, input logic [2:0] in, ex);
    u_host.set_lines(1'h0, in[2]);
    cfg_i.flow_control = f;
    cfg_i.line_interface_select = ifc;
    {tx_active_i, rx_space_i} = in[1:0];
    tick(1);
    chk("cts", pins_o.cts, ex[2]);
    chk("tx_allowed_o", tx_allowed_o, ex[1]);
    chk("cfg_error_o", cfg_error_o, ex[0]);
  endtask : flow_case
  task automatic pulse(input logic data);
    if (data) enter_data_i = 1'h1;
    else enter_command_i = 1'h1;
    tick(1);
    {enter_data_i, enter_command_i} = 2'h0;
  endtask : pulse
  task automatic mode_chk(input logic dm, input logic dsr);
    chk("data_mode_o", data_mode_o, dm);
    chk("dsr_level", pins_o.dsr_level, dsr);
  endtask : mode_chk
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 800) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    tick(5);
    chk("dcd_on", pins_o.dcd_on, 1'h0);
    chk("data_mode_o", data_mode_o, 1'h0);
    chk("cfg_error_o", cfg_error_o, 1'h0);
    nrst_i = 1'h1;
    tick(3);
    dcd_case(DCD_ALWAYS, 4'h0, 1'h1);
    dcd_case(DCD_SYNC_IDLE, 4'ha, 1'h1);
    dcd_case(DCD_SYNC_IDLE, 4'h8, 1'h0);
    dcd_case(DCD_SYNC_IDLE, 4'h4, 1'h1);
    dcd_case(DCD_SYNC_IDLE, 4'h5, 1'h0);
    dcd_case(DCD_SYNC_BUSY, 4'h5, 1'h1);
    dcd_case(DCD_SYNC_BUSY, 4'h4, 1'h0);
    dcd_case(DCD_SYNC_BUSY, 4'hb, 1'h1);
    flow_case(FLOW_RTS_CTS, 2'h0, 3'h2, 3'h0);
    flow_case(FLOW_RTS_CTS, 2'h0, 3'h5, 3'h6);
    flow_case(FLOW_RTS_CTS, 2'h1, 3'h7, 3'h7);
    flow_case(FLOW_RS485, 2'h1, 3'h2, 3'h6);
    flow_case(FLOW_RS485, 2'h3, 3'h5, 3'h2);
    flow_case(FLOW_RS485, 2'h0, 3'h2, 3'h7);
    flow_case(FLOW_NONE, 2'h0, 3'h0, 3'h6);
    flow_case(FLOW_NONE, 2'h2, 3'h0, 3'h7);
    u_host.set_lines(1'h1, 1'h1);
    cfg_i = {DCD_ALWAYS, DTR_DROP, FLOW_NONE, DSR_BY_MODE, IFACE_RS232};
    tick(5);
    pulse(1'h1);
    mode_chk(1'h1, DSR_ON_LEVEL);
    u_host.set_lines(1'h0, 1'h1);
    tick(2);
    chk("data_mode_o", data_mode_o, 1'h1);
    tick(1);
    chk("drop_link_o", drop_link_o, 1'h1);
    mode_chk(1'h0, DSR_OFF_LEVEL);
    tick(1);
    pulse(1'h1);
    chk("data_refused_o", data_refused_o, 1'h1);
    chk("data_mode_o", data_mode_o, 1'h0);
    u_host.set_lines(1'h1, 1'h1);
    tick(4);
    pulse(1'h1);
    mode_chk(1'h1, DSR_ON_LEVEL);
    cfg_i.dtr_policy = DTR_IGNORE;
    u_host.set_lines(1'h0, 1'h1);
    tick(5);
    chk("data_mode_o", data_mode_o, 1'h1);
    cfg_i.dsr_policy = DSR_ALWAYS;
    pulse(1'h0);
    mode_chk(1'h0, DSR_ON_LEVEL);
    cfg_i.dcd_policy = 3'h2;
    radio_i = 4'h8;
    tick(1);
    chk("dcd_on", pins_o.dcd_on, 1'h1);
    chk("cfg_error_o", cfg_error_o, 1'h1);
    cfg_i.dcd_policy = DCD_ALWAYS;
    cfg_i.dtr_policy = 2'h1;
    tick(1);
    chk("cfg_error_o", cfg_error_o, 1'h1);
    cfg_i.dtr_policy = DTR_IGNORE;
    tick(1);
    chk("cfg_error_o", cfg_error_o, 1'h0);
    end_sim();
  end
endmodule : serial_modem_control_lines_tb_top
